// File: asa_params.svh
`ifndef ASA_PARAMS_SVH
`define ASA_PARAMS_SVH

// ===========================================
// Sizes and timing
`define ASA_NUM_OUTPUTS     12
`define ASA_NUM_ALARM_PINS  3
`define ASA_FILTER_TIME_NS  40
`define ASA_CLK_PERIOD_NS   4
`define ASA_FILTER_CYCLES   ((`ASA_FILTER_TIME_NS + `ASA_CLK_PERIOD_NS - 1) / `ASA_CLK_PERIOD_NS)

// ===========================================
// Query answer field positions
`define ASA_QRY_SRC_A_BIT   1
`define ASA_QRY_SRC_B_BIT   0

`endif

// File: asa_pkg.sv
package asa_pkg;
  typedef enum logic {ASA_SEL_A, ASA_SEL_B} asa_sel_t;
  typedef enum logic [1:0] {ASA_ST_AUTO_A, ASA_ST_AUTO_B, ASA_ST_MANUAL} asa_state_t;
endpackage

// File: asa_alarm_filter.sv
`timescale 1ns/1ps
`include "asa_params.svh"

// Two-stage synchroniser followed by a stability filter on one active-low line
module asa_alarm_filter #(
  parameter int CYCLES = `ASA_FILTER_CYCLES
) (
  input  wire logic mclk,
  input  wire logic sys_rst,
  input  wire logic line_n,
  output logic      alarm
);
  logic       sync1_ff;
  logic       sync2_ff;
  logic       nxt_sync1;
  logic       nxt_sync2;
  logic [7:0] cnt_ff;
  logic [7:0] nxt_cnt;
  logic       alarm_ff;
  logic       nxt_alarm;

  // ===========================================
  // Synchroniser and filter
  always_comb begin
    nxt_sync1 = line_n;
    nxt_sync2 = sync1_ff;
    nxt_cnt   = cnt_ff;
    nxt_alarm = alarm_ff;
    // Low level means alarm; a change must hold CYCLES clocks before it counts
    if ((~sync2_ff) == alarm_ff) begin
      nxt_cnt = 8'h00;
    end else if (cnt_ff == 8'(CYCLES - 1)) begin
      nxt_cnt   = 8'h00;
      nxt_alarm = ~sync2_ff;
    end else begin
      nxt_cnt = cnt_ff + 8'h01;
    end
  end

  always_ff @(posedge mclk) begin
    if (sys_rst) begin
      sync1_ff <= 1'b1;
      sync2_ff <= 1'b1;
      cnt_ff   <= 8'h00;
      alarm_ff <= 1'b0;
    end else begin
      sync1_ff <= nxt_sync1;
      sync2_ff <= nxt_sync2;
      cnt_ff   <= nxt_cnt;
      alarm_ff <= nxt_alarm;
    end
  end

  assign alarm = alarm_ff;
endmodule // asa_alarm_filter

// File: asa_alarm_status_aggregator.sv
`timescale 1ns/1ps
`include "asa_params.svh"

// What this block does
// R1 - Alarm outputs all high without alarm, all low together with any alarm
// R2 - Alarm outputs always match the front-panel alarm lamp
// R3 - Sources hold alarm lines high normally, low means alarm
// R4 - Input A source reports on first alarm line, input B on second
// R5 - Source A alarm selects input B, raises alarm, records first-line flag
// R6 - Source B alarm selects away from B, raises alarm, records second-line flag
// R7 - Query answers both source flags, first line first
// R8 - Alarm on faulty output, no input signal, or any source alarm
// R9 - Input presence lamps follow valid signal detection
// R10 - Twelve output lamps, each lit only while its output works
// R11 - Power lamp follows supply presence only, no serial control
// R12 - One input at a time, A preferred, automatic switch on loss
// R13 - After failover stay on B until B fails with A good, auto disabled with A chosen, or A selected and auto re-enabled
// R14 - Source alarm lines synchronised two-stage and stability filtered
module asa_alarm_status_aggregator #(
  parameter int NUM_OUTPUTS = `ASA_NUM_OUTPUTS,
  parameter int NUM_PINS    = `ASA_NUM_ALARM_PINS,
  parameter int FILTER_CYC  = `ASA_FILTER_CYCLES
) (
  input  wire logic                   mclk,
  input  wire logic                   sys_rst,
  input  wire logic [1:0]             source_alarm_in_n,
  input  wire logic [1:0]             input_present,
  input  wire logic [NUM_OUTPUTS-1:0] output_ok,
  input  wire logic                   supply_present,
  input  wire logic                   input_select_cmd,
  input  wire logic                   input_select_b,
  input  wire logic                   auto_switch_enable_cmd,
  input  wire logic                   auto_switch_on,
  input  wire logic                   source_alarm_query,
  output logic [NUM_PINS-1:0]         alarm_status_out_n,
  output logic                        alarm_lamp,
  output logic [1:0]                  input_lamp,
  output logic [NUM_OUTPUTS-1:0]      output_lamp,
  output logic                        power_lamp,
  output logic                        select_b,
  output logic                        auto_switch_active,
  output logic                        query_valid,
  output logic [1:0]                  query_flags
);
  logic [1:0]             pres_s1_ff;
  logic [1:0]             pres_ff;
  logic [NUM_OUTPUTS-1:0] ok_s1_ff;
  logic [NUM_OUTPUTS-1:0] ok_ff;
  logic [1:0]             src_alarm;
  logic                   alarm_any;
  asa_pkg::asa_state_t    state_ff;
  asa_pkg::asa_state_t    nxt_state;
  asa_pkg::asa_sel_t      man_sel_ff;
  asa_pkg::asa_sel_t      nxt_man_sel;
  logic                   alarm_ff;
  logic                   nxt_alarm;
  logic                   qv_ff;
  logic                   nxt_qv;
  logic [1:0]             qf_ff;
  logic [1:0]             nxt_qf;
  logic [1:0]             nxt_pres_s1;
  logic [1:0]             nxt_pres;
  logic [NUM_OUTPUTS-1:0] nxt_ok_s1;
  logic [NUM_OUTPUTS-1:0] nxt_ok;
  // Status outputs are registered so lamps never see decode glitches
  logic                   sel_b_ff;
  logic                   nxt_sel_b;
  logic                   auto_act_ff;
  logic                   nxt_auto_act;

  // ===========================================
  // Source alarm lines
  // One filter per source line; a source may bounce while it changes state
  genvar g;
  generate
    for (g = 0; g < 2; g++) begin : g_src
      asa_alarm_filter #(
        .CYCLES (FILTER_CYC)
      ) u_filt (
        .mclk    (mclk),
        .sys_rst (sys_rst),
        .line_n  (source_alarm_in_n[g]),  // R3 R4
        .alarm   (src_alarm[g])           // R14
      );
    end
  endgenerate

  // ===========================================
  // Detector levels arrive from analog sense circuits, so synchronise them
  // Only the second stage is read; the first may still be settling
  always_comb begin
    nxt_pres_s1 = input_present;
    nxt_pres    = pres_s1_ff;
    nxt_ok_s1   = output_ok;
    nxt_ok      = ok_s1_ff;
  end

  always_ff @(posedge mclk) begin
    if (sys_rst) begin
      pres_s1_ff <= 2'h0;
      pres_ff    <= 2'h0;
      ok_s1_ff   <= '0;
      ok_ff      <= '0;
    end else begin
      pres_s1_ff <= nxt_pres_s1;
      pres_ff    <= nxt_pres;
      ok_s1_ff   <= nxt_ok_s1;
      ok_ff      <= nxt_ok;
    end
  end

  // Any single cause is enough; the lamp does not say which one
  assign alarm_any = (~&ok_ff) | (pres_ff == 2'h0) | (|src_alarm); // R8

  // ===========================================
  // Input selection
  always_comb begin
    nxt_state   = state_ff;
    nxt_man_sel = man_sel_ff;
    if (input_select_cmd) begin
      nxt_man_sel = input_select_b ? asa_pkg::ASA_SEL_B : asa_pkg::ASA_SEL_A;
    end
    unique case (state_ff)
      asa_pkg::ASA_ST_AUTO_A: begin
        // A fails by loss of signal or its source alarm, and B has signal; B's source alarm is not checked
        if ((!pres_ff[0] || src_alarm[0]) && pres_ff[1]) begin
          nxt_state = asa_pkg::ASA_ST_AUTO_B; // R5 R12
        end
      end
      asa_pkg::ASA_ST_AUTO_B: begin
        // Recovery of A alone does not bring us back
        if ((!pres_ff[1] || src_alarm[1]) && pres_ff[0] && !src_alarm[0]) begin
          nxt_state = asa_pkg::ASA_ST_AUTO_A; // R6 R12
        end
      end
      asa_pkg::ASA_ST_MANUAL: ;
      // The fourth code is unreachable; fall back to the preferred input
      default: nxt_state = asa_pkg::ASA_ST_AUTO_A;
    endcase
    if (auto_switch_enable_cmd) begin
      if (!auto_switch_on) begin
        nxt_state = asa_pkg::ASA_ST_MANUAL;
      end else begin
        // Re-enabling auto starts from the manually chosen input
        nxt_state = (nxt_man_sel == asa_pkg::ASA_SEL_A) ? asa_pkg::ASA_ST_AUTO_A
                                                        : asa_pkg::ASA_ST_AUTO_B; // R13
      end
    end else if (input_select_cmd && state_ff == asa_pkg::ASA_ST_AUTO_B
                 && nxt_man_sel == asa_pkg::ASA_SEL_A) begin
      // Selecting A alone while failed over is not enough to return
      nxt_state = asa_pkg::ASA_ST_AUTO_B; // R13
    end
    // Decoded from the next values so the flops move with the state
    nxt_auto_act = (nxt_state != asa_pkg::ASA_ST_MANUAL);
    nxt_sel_b    = (nxt_state == asa_pkg::ASA_ST_AUTO_B) ||
                   (nxt_state == asa_pkg::ASA_ST_MANUAL && nxt_man_sel == asa_pkg::ASA_SEL_B); // R12
  end

  always_ff @(posedge mclk) begin
    if (sys_rst) begin
      state_ff    <= asa_pkg::ASA_ST_AUTO_A;
      man_sel_ff  <= asa_pkg::ASA_SEL_A;
      sel_b_ff    <= 1'b0;
      auto_act_ff <= 1'b1;
    end else begin
      state_ff    <= nxt_state;
      man_sel_ff  <= nxt_man_sel;
      sel_b_ff    <= nxt_sel_b;
      auto_act_ff <= nxt_auto_act;
    end
  end

  // ===========================================
  // Aggregated alarm
  always_comb begin
    nxt_alarm = alarm_any; // R8
  end

  always_ff @(posedge mclk) begin
    if (sys_rst) begin
      alarm_ff <= 1'b0;
    end else begin
      alarm_ff <= nxt_alarm;
    end
  end

  // ===========================================
  // Query
  // Flags hold between queries so a slow reader sees a steady answer
  always_comb begin
    nxt_qv    = source_alarm_query;
    nxt_qf    = qf_ff;
    if (source_alarm_query) begin
      nxt_qf[`ASA_QRY_SRC_A_BIT] = src_alarm[0]; // R7
      nxt_qf[`ASA_QRY_SRC_B_BIT] = src_alarm[1]; // R7
    end
  end

  always_ff @(posedge mclk) begin
    if (sys_rst) begin
      qv_ff <= 1'b0;
      qf_ff <= 2'h0;
    end else begin
      qv_ff <= nxt_qv;
      qf_ff <= nxt_qf;
    end
  end

  // ===========================================
  // Outputs
  // All alarm pins share one flop so they can never disagree
  assign alarm_status_out_n = {NUM_PINS{~alarm_ff}}; // R1
  assign alarm_lamp         = alarm_ff;              // R2
  assign input_lamp         = pres_ff;               // R9
  assign output_lamp        = ok_ff;                 // R10
  // Power lamp is a plain wire from the supply sense, with no register behind it
  assign power_lamp         = supply_present;        // R11
  assign select_b           = sel_b_ff;              // R12
  assign auto_switch_active = auto_act_ff;           // R13
  assign query_valid        = qv_ff;
  assign query_flags        = qf_ff;
endmodule // asa_alarm_status_aggregator

// File: asa_src_model.sv
`timescale 1ns/1ps
// ====================
// Reference sources: alarm lines idle high, pulled low on a fault
module asa_src_model (
  input logic        mclk,
  input logic [1:0]  fail,
  input logic [1:0]  glitch,
  output logic [1:0] line_n
);
  // One cycle late, as a slow source would be
  initial begin
    line_n = 2'h3;
    forever begin
      @(posedge mclk);
      line_n <= ~(fail | glitch);
    end
  end
endmodule // asa_src_model

// File: asa_alarm_status_aggregator_chk.sv
`timescale 1ns/1ps
// ====================
// Port-level checks
module asa_alarm_chk #(
  parameter int NUM_OUTPUTS = 12,
  parameter int NUM_PINS    = 3
) (
  input logic                   mclk,
  input logic                   sys_rst,
  input logic [1:0]             source_alarm_in_n,
  input logic [1:0]             input_present,
  input logic [NUM_OUTPUTS-1:0] output_ok,
  input logic                   supply_present,
  input logic                   input_select_cmd,
  input logic                   auto_switch_enable_cmd,
  input logic                   source_alarm_query,
  input logic [NUM_PINS-1:0]    alarm_status_out_n,
  input logic                   alarm_lamp,
  input logic [1:0]             input_lamp,
  input logic                   power_lamp,
  input logic                   select_b,
  input logic                   auto_switch_active,
  input logic                   query_valid
);
  // Commands may legally move the selection, so they mask the routing checks
  wire quiet = !input_select_cmd && !auto_switch_enable_cmd;
  default clocking cb @(posedge mclk); endclocking
  default disable iff (sys_rst);
  a_out_all_same: assert property (&alarm_status_out_n || ~|alarm_status_out_n)
    else $error("alarm outputs differ");
  a_lamp_echo: assert property (alarm_lamp != alarm_status_out_n[0])
    else $error("alarm lamp differs from outputs");
  a_power_direct: assert property (power_lamp == supply_present)
    else $error("power lamp wrong");
  a_query_answer: assert property (source_alarm_query |=> query_valid)
    else $error("query unanswered");
  a_src_alarm_seen: assert property (!source_alarm_in_n[0] [*8] |-> alarm_lamp)
    else $error("source alarm not shown");
  a_no_cause_clear: assert property ((&source_alarm_in_n && |input_present && &output_ok) [*8] |-> !alarm_lamp)
    else $error("alarm without cause");
  a_in_lamp_follow: assert property ($stable(input_present) [*4] |-> input_lamp == input_present)
    else $error("input lamp wrong");
  a_fail_to_b: assert property ((quiet && auto_switch_active && !source_alarm_in_n[0]
    && source_alarm_in_n[1] && input_present[1]) [*8] |-> select_b)
    else $error("no failover to B");
  a_stay_on_b: assert property ((quiet && select_b && source_alarm_in_n[1] && input_present[1]) [*8] |=> select_b)
    else $error("left B without command");
endmodule // asa_alarm_chk

bind asa_alarm_status_aggregator asa_alarm_chk #(
  .NUM_OUTPUTS (NUM_OUTPUTS),
  .NUM_PINS    (NUM_PINS)
) i_asa_alarm_chk (
  .mclk                   (mclk),
  .sys_rst                (sys_rst),
  .source_alarm_in_n      (source_alarm_in_n),
  .input_present          (input_present),
  .output_ok              (output_ok),
  .supply_present         (supply_present),
  .input_select_cmd       (input_select_cmd),
  .auto_switch_enable_cmd (auto_switch_enable_cmd),
  .source_alarm_query     (source_alarm_query),
  .alarm_status_out_n     (alarm_status_out_n),
  .alarm_lamp             (alarm_lamp),
  .input_lamp             (input_lamp),
  .power_lamp             (power_lamp),
  .select_b               (select_b),
  .auto_switch_active     (auto_switch_active),
  .query_valid            (query_valid)
);

// File: tb_asa_alarm_status_aggregator.sv
`timescale 1ns/1ps
module tb_asa_alarm_status_aggregator;
  logic        mclk = 0, sys_rst = 1, supply_present = 1, source_alarm_query = 0;
  logic        input_select_cmd = 0, input_select_b = 0, auto_switch_enable_cmd = 0, auto_switch_on = 0;
  logic        alarm_lamp, power_lamp, select_b, auto_switch_active, query_valid;
  logic [1:0]  fail = 0, glitch = 0, input_present = 2'h3, source_alarm_in_n, input_lamp, query_flags;
  logic [2:0]  alarm_status_out_n;
  logic [11:0] output_ok = 12'hfff, output_lamp;
  logic [22:0] exp_q[$];
  logic        exp_auto = 1;
  int          failures = 0, total_checks = 0;

  asa_alarm_status_aggregator #(
    .FILTER_CYC (2)
  ) i_asa_alarm_status_aggregator (
    .mclk                   (mclk),
    .sys_rst                (sys_rst),
    .source_alarm_in_n      (source_alarm_in_n),
    .input_present          (input_present),
    .output_ok              (output_ok),
    .supply_present         (supply_present),
    .input_select_cmd       (input_select_cmd),
    .input_select_b         (input_select_b),
    .auto_switch_enable_cmd (auto_switch_enable_cmd),
    .auto_switch_on         (auto_switch_on),
    .source_alarm_query     (source_alarm_query),
    .alarm_status_out_n     (alarm_status_out_n),
    .alarm_lamp             (alarm_lamp),
    .input_lamp             (input_lamp),
    .output_lamp            (output_lamp),
    .power_lamp             (power_lamp),
    .select_b               (select_b),
    .auto_switch_active     (auto_switch_active),
    .query_valid            (query_valid),
    .query_flags            (query_flags)
  );
  asa_src_model i_asa_src_model (.mclk(mclk), .fail(fail), .glitch(glitch), .line_n(source_alarm_in_n));

  initial forever #2 mclk = ~mclk;

  // ====================
  // Driver notes the expected answer, then queries
  task automatic chk(input logic [1:0] f, input logic [1:0] p, input logic [11:0] o, input logic s);
    logic a;
    @(negedge mclk);
    fail = f;
    input_present = p;
    output_ok = o;
    supply_present = 1'($urandom);
    repeat (10) @(negedge mclk);
    a = |f | ~&o | ~|p;
    exp_q.push_back({a, {3{~a}}, s, f[0], f[1], p, o, supply_present, exp_auto});
    source_alarm_query = 1;
    @(negedge mclk);
    source_alarm_query = 0;
  endtask

  task automatic cmd(input logic b, input logic on);
    @(negedge mclk);
    input_select_b = b;
    auto_switch_on = on;
    exp_auto = on;
    input_select_cmd = 1;
    auto_switch_enable_cmd = 1;
    @(negedge mclk);
    input_select_cmd = 0;
    auto_switch_enable_cmd = 0;
  endtask

  task automatic sel(input logic b);
    @(negedge mclk);
    input_select_b = b;
    input_select_cmd = 1;
    @(negedge mclk);
    input_select_cmd = 0;
  endtask

  task automatic final_report();
    if (exp_q.size() != 0) begin
      failures++;
      $display("[ERR] %0t expected query answer never seen", $time);
    end
    $display("checks=%0d failures=%0d", total_checks, failures);
    if (failures == 0 && total_checks > 0) begin
      $display("== PASSED ==");
    end else begin
      $display("== FAILED ==");
    end
    $finish;
  endtask

  // ====================
  // Monitor
  always @(negedge mclk) begin
    if (query_valid === 1'b1) begin
      total_checks++;
      if (exp_q.size() == 0 || {alarm_lamp, alarm_status_out_n, select_b, query_flags, input_lamp, output_lamp,
          power_lamp, auto_switch_active} !== exp_q.pop_front()) begin
        failures++;
        $display("[ERR] %0t query result mismatch", $time);
      end
    end
  end

  initial begin
    void'($urandom(32'hd275));
    repeat (16) @(negedge mclk);
    sys_rst = 0;
    chk(2'h0, 2'h3, 12'hfff, 0);
    chk(2'h1, 2'h3, 12'hfff, 1);
    chk(2'h0, 2'h3, 12'hfff, 1);
    sel(0);
    chk(2'h0, 2'h3, 12'hfff, 1);
    cmd(0, 1);
    chk(2'h0, 2'h3, 12'hfff, 0);
    chk(2'h1, 2'h3, 12'hfff, 1);
    chk(2'h2, 2'h3, 12'hfff, 0);
    cmd(1, 0);
    chk(2'h0, 2'h3, 12'hfff, 1);
    cmd(0, 1);
    chk(2'h0, 2'h3, ~(12'h1 << ($urandom % 12)), 0);
    chk(2'h0, 2'h0, 12'hfff, 0);
    @(negedge mclk);
    glitch = 2'h1;
    @(negedge mclk);
    glitch = 2'h0;
    chk(2'h0, 2'h3, 12'hfff, 0);
    repeat (4) @(negedge mclk);
    final_report();
  end

  initial begin
    #4000;
    failures++;
    $display("[ERR] %0t watchdog expired", $time);
    final_report();
  end
endmodule // tb_asa_alarm_status_aggregator
